// ==== hw/flash_block_write_guard.sv ====
// flash block write guard: protection maps, debug bypass and request check
//
// Behaviour
// - low map at 0x600, write-one-to-set
// - high map at 0x604, sixteen bits used
// - debug bypass at 0x608, resets to one
// - bypass acts only in debug mode
// - registers sit at base 0x40000000
// - one bit guards one 4 kB block
// - protected erase/write blocked, hard fault raised
// - full wipe refused if any bit set
// - maps cleared only by reset
//
// notes for the next engineer:
// - the maps only ever gain bits; a soft reset is the one way back, which
//   keeps stray firmware from unlocking a block it should not touch
// - the request check is purely combinational into one flop, so a request
//   is answered exactly one cycle after it is taken; there is no queue
// - the flash controller must wait for grant or fault before it acts
// - clk_en low freezes maps, read data and answers alike
// - requests beyond the mapped blocks pass unguarded by design
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
module flash_block_write_guard
  import flash_guard_pkg::*;
#(
  parameter int ADDR_W = 32  // flash request address width
)
(
  input  wire logic              ref_clk,      // 40 MHz system clock
  input  wire logic              rst,          // synchronous reset, active high
  input  wire logic              clk_en,       // freezes all state while low
  input  wire logic [31:0]       bus_addr,     // register byte address
  input  wire logic [31:0]       bus_wdata,    // register write data
  input  wire logic              bus_write,    // write strobe
  input  wire logic              bus_read,     // read strobe
  output logic      [31:0]       bus_rdata,    // read data, cycle after strobe
  input  wire logic              debug_mode,   // debugger attached
  input  wire logic              req_valid,    // erase or write request
  input  wire logic [ADDR_W-1:0] req_addr,     // request flash byte address
  input  wire logic              req_wipe,     // request is a full wipe
  output logic                   req_grant,    // request passed to flash, pulse
  output logic                   hard_fault    // fault to processor, pulse
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // base match
  wire        base_hit   = (bus_addr[31:12] == GUARD_BASE_ADDR[31:12]);
  wire [11:0] off        = bus_addr[11:0];
  wire        sel_low    = base_hit && (off == OFF_PROTECT_LOW);
  wire        sel_high   = base_hit && (off == OFF_PROTECT_HIGH);
  wire        sel_dbg    = base_hit && (off == OFF_DEBUG_UNPROT);
  wire        sel_spare  = base_hit && (off == OFF_SPARE_SLOT);

  logic [31:0]           prot_low_q;
  logic [HIGH_BITS-1:0]  prot_high_q;
  logic                  dbg_unprot_q;

  // maps write-one-to-set, zero bits keep their value; bypass takes bit 0 as written
  wire [31:0] prot_low_d = (bus_write && sel_low) ? (prot_low_q | bus_wdata) : prot_low_q;
  wire [HIGH_BITS-1:0] prot_high_d =
    (bus_write && sel_high) ? (prot_high_q | bus_wdata[HIGH_BITS-1:0]) : prot_high_q;
  wire dbg_unprot_d = (bus_write && sel_dbg) ? bus_wdata[0] : dbg_unprot_q;

  // read mux; unmapped and spare slot read as zero
  wire [31:0] rdata_d = !bus_read ? 32'h0000_0000 :
                        sel_low   ? prot_low_q :
                        sel_high  ? {16'h0000, prot_high_q} :
                        sel_dbg   ? {31'h0000_0000, dbg_unprot_q} :
                                    32'h0000_0000;

  // ----------------------------------------------------------------
  // protection check
  // ----------------------------------------------------------------
  // bit n of word k guards block k*32+n
  wire [NUM_BLOCKS-1:0] block_map = {prot_high_q, prot_low_q};
  // index is address shifted by block size; high blocks unguarded
  wire [ADDR_W-1:0] blk_idx = req_addr >> BLOCK_SHIFT;
  wire              idx_ok  = (blk_idx < ADDR_W'(NUM_BLOCKS));
  localparam int    IDX_W   = $clog2(NUM_BLOCKS);
  wire              blk_bit = idx_ok ? block_map[blk_idx[IDX_W-1:0]] : 1'b0;
  // bypass only counts in debug mode
  wire              guard_on = !(debug_mode && dbg_unprot_q);
  // wipe refused if any block is guarded
  wire              wipe_bad = req_wipe && (|block_map);
  wire              deny     = guard_on && (wipe_bad || (!req_wipe && blk_bit));
  wire              fault_d  = req_valid && deny;
  wire              grant_d  = req_valid && !deny;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // only reset clears the maps
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      prot_low_q   <= RST_PROTECT_LOW;
      prot_high_q  <= RST_PROTECT_HIGH;
      dbg_unprot_q <= RST_DEBUG_UNPROT;
    end
    else if (clk_en)
    begin
      prot_low_q   <= prot_low_d;
      prot_high_q  <= prot_high_d;
      dbg_unprot_q <= dbg_unprot_d;
    end
  end

  // read data register; zero between reads while clk_en is high, so stale data does not linger
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      bus_rdata <= 32'h0000_0000;
    else if (clk_en)
      bus_rdata <= rdata_d;
  end

  // request answer, one pulse per request
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      req_grant  <= 1'b0;
      hard_fault <= 1'b0;
    end
    else if (clk_en)
    begin
      req_grant  <= grant_d;
      hard_fault <= fault_d;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // bits never fall without reset
  property p_low_sticky;
    @(posedge ref_clk) disable iff (rst)
      !$past(rst) |-> ((~prot_low_q & $past(prot_low_q)) == 32'h0);
  endproperty
  a_low_sticky: assert property (p_low_sticky) else $error("low map bit cleared");

  // high map sets from a write
  property p_high_set;
    @(posedge ref_clk) disable iff (rst)
      (clk_en && bus_write && sel_high) |=> ((prot_high_q & $past(bus_wdata[HIGH_BITS-1:0])) ==
      $past(bus_wdata[HIGH_BITS-1:0]));
  endproperty
  a_high_set: assert property (p_high_set) else $error("high map not set");

  property p_dbg_write;
    @(posedge ref_clk) disable iff (rst)
      (clk_en && bus_write && sel_dbg) |=> (dbg_unprot_q == $past(bus_wdata[0]));
  endproperty
  a_dbg_write: assert property (p_dbg_write) else $error("bypass write lost");

  // outside debug, guarded block always faults
  property p_no_debug_guard;
    @(posedge ref_clk) disable iff (rst)
      (clk_en && req_valid && !req_wipe && blk_bit && !debug_mode) |=> (hard_fault && !req_grant);
  endproperty
  a_no_debug_guard: assert property (p_no_debug_guard) else $error("guard skipped outside debug");

  property p_exclusive;
    @(posedge ref_clk) disable iff (rst) !(hard_fault && req_grant);
  endproperty
  a_exclusive: assert property (p_exclusive) else $error("fault and grant together");

  // wipe with a set bit faults
  property p_wipe;
    @(posedge ref_clk) disable iff (rst)
      (clk_en && req_valid && req_wipe && (|block_map) && guard_on) |=> hard_fault;
  endproperty
  a_wipe: assert property (p_wipe) else $error("full wipe not refused");

  // blocks past the map always granted
  property p_beyond;
    @(posedge ref_clk) disable iff (rst)
      (clk_en && req_valid && !req_wipe && !idx_ok) |=> req_grant;
  endproperty
  a_beyond: assert property (p_beyond) else $error("unmapped block refused");

  // reset leaves maps clear and bypass set
  property p_reset_vals;
    @(posedge ref_clk) $past(rst) |-> (prot_low_q == 32'h0 && prot_high_q == 16'h0 && dbg_unprot_q);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");

  property p_readback;
    @(posedge ref_clk) disable iff (rst)
      (clk_en && bus_read && sel_low) |=> (bus_rdata == $past(prot_low_q));
  endproperty
  a_readback: assert property (p_readback) else $error("low map readback wrong");

  property p_low_set;
    @(posedge ref_clk) disable iff (rst)
      (clk_en && bus_write && sel_low) |=> ((prot_low_q & $past(bus_wdata)) == $past(bus_wdata));
  endproperty
  a_low_set: assert property (p_low_set) else $error("low map not set");

  // high bits never fall without reset
  property p_high_sticky;
    @(posedge ref_clk) disable iff (rst)
      !$past(rst) |-> ((~prot_high_q & $past(prot_high_q)) == RST_PROTECT_HIGH);
  endproperty
  a_high_sticky: assert property (p_high_sticky) else $error("high map bit cleared");

  // high readback zero-fills the unused half
  property p_high_readback;
    @(posedge ref_clk) disable iff (rst)
      (clk_en && bus_read && sel_high) |=> (bus_rdata == 32'($past(prot_high_q)));
  endproperty
  a_high_readback: assert property (p_high_readback) else $error("high map readback wrong");

  property p_dbg_readback;
    @(posedge ref_clk) disable iff (rst)
      (clk_en && bus_read && sel_dbg) |=> (bus_rdata == 32'($past(dbg_unprot_q)));
  endproperty
  a_dbg_readback: assert property (p_dbg_readback) else $error("bypass readback wrong");

  // bypass in debug lets any request through
  property p_bypass_grant;
    @(posedge ref_clk) disable iff (rst)
      (clk_en && req_valid && debug_mode && dbg_unprot_q) |=> (req_grant && !hard_fault);
  endproperty
  a_bypass_grant: assert property (p_bypass_grant) else $error("bypass did not grant");

  property p_foreign_read;
    @(posedge ref_clk) disable iff (rst)
      (clk_en && bus_read && !base_hit) |=> (bus_rdata == 32'h0000_0000);
  endproperty
  a_foreign_read: assert property (p_foreign_read) else $error("foreign address read nonzero");

  property p_spare_read;
    @(posedge ref_clk) disable iff (rst)
      (clk_en && bus_read && sel_spare) |=> (bus_rdata == 32'h0000_0000);
  endproperty
  a_spare_read: assert property (p_spare_read) else $error("spare slot read nonzero");

  // read data stands only after a read
  property p_idle_rdata;
    @(posedge ref_clk) disable iff (rst)
      (clk_en && !bus_read) |=> (bus_rdata == 32'h0000_0000);
  endproperty
  a_idle_rdata: assert property (p_idle_rdata) else $error("read data without read");

  // guarded in-range block faults when guard is on
  property p_guarded_fault;
    @(posedge ref_clk) disable iff (rst)
      (clk_en && req_valid && !req_wipe && blk_bit && guard_on) |=> hard_fault;
  endproperty
  a_guarded_fault: assert property (p_guarded_fault) else $error("guarded block not refused");

  property p_free_grant;
    @(posedge ref_clk) disable iff (rst)
      (clk_en && req_valid && !req_wipe && !blk_bit) |=> req_grant;
  endproperty
  a_free_grant: assert property (p_free_grant) else $error("free block refused");

  property p_no_req_quiet;
    @(posedge ref_clk) disable iff (rst)
      (clk_en && !req_valid) |=> (!req_grant && !hard_fault);
  endproperty
  a_no_req_quiet: assert property (p_no_req_quiet) else $error("answer without request");

  // wipe with empty maps is granted
  property p_wipe_empty;
    @(posedge ref_clk) disable iff (rst)
      (clk_en && req_valid && req_wipe && !(|block_map)) |=> req_grant;
  endproperty
  a_wipe_empty: assert property (p_wipe_empty) else $error("wipe refused with empty maps");

  // clock enable low holds every setting
  property p_freeze;
    @(posedge ref_clk) disable iff (rst)
      !clk_en |=> ($stable(prot_low_q) && $stable(prot_high_q) && $stable(dbg_unprot_q));
  endproperty
  a_freeze: assert property (p_freeze) else $error("settings moved while frozen");

  c_fault: cover property (@(posedge ref_clk) disable iff (rst) hard_fault);
  c_grant: cover property (@(posedge ref_clk) disable iff (rst) req_grant);
  c_bypass: cover property (@(posedge ref_clk) disable iff (rst)
    (req_valid && blk_bit && !guard_on));
  c_wipe: cover property (@(posedge ref_clk) disable iff (rst) (req_valid && req_wipe && wipe_bad));
  c_freeze: cover property (@(posedge ref_clk) disable iff (rst) (!clk_en && bus_write));

endmodule : flash_block_write_guard

// ==== hw/flash_guard_pkg.sv ====
// constants for the flash block write guard
package flash_guard_pkg;
  localparam logic [31:0] GUARD_BASE_ADDR    = 32'h4000_0000;
  localparam logic [11:0] OFF_PROTECT_LOW    = 12'h600;
  localparam logic [11:0] OFF_PROTECT_HIGH   = 12'h604;
  localparam logic [11:0] OFF_DEBUG_UNPROT   = 12'h608;
  localparam logic [11:0] OFF_SPARE_SLOT     = 12'h60c;
  localparam logic [31:0] RST_PROTECT_LOW    = 32'h0000_0000;
  localparam logic [15:0] RST_PROTECT_HIGH   = 16'h0000;
  localparam logic        RST_DEBUG_UNPROT   = 1'b1;
  localparam int          BLOCK_BYTES        = 4096;
  localparam int          BLOCK_SHIFT        = 12;
  localparam int          NUM_BLOCKS         = 48;
  localparam int          HIGH_BITS          = 16;
endpackage : flash_guard_pkg

// ==== test/flash_req_model.sv ====
// flash request source standing in for the processor side
`timescale 1ns/10ps
module flash_req_model
(
  input  wire logic        ref_clk,   // system clock
  input  wire logic        go,        // issue one request
  input  wire logic [31:0] addr,      // request byte address
  input  wire logic        wipe,      // full wipe wanted
  output logic             req_valid, // one-cycle request
  output logic      [31:0] req_addr,  // address, flips when idle
  output logic             req_wipe   // low when idle
);
  // idle address toggles so a stale value never looks like a request
  always_ff @(posedge ref_clk)
  begin
    req_valid <= go;
    req_addr  <= go ? addr : ~req_addr;
    req_wipe  <= go & wipe;
  end
endmodule : flash_req_model

// ==== test/flash_block_write_guard_tb.sv ====
// self-checking bench for the flash block write guard
`timescale 1ns/10ps
module flash_block_write_guard_tb;
  import flash_guard_pkg::*;
  logic        ref_clk = 0, rst = 1, bus_write = 0, bus_read = 0, debug_mode = 0, go = 0, wipe = 0;
  logic [31:0] bus_addr = '0, bus_wdata = '0, addr = '0, bus_rdata, req_addr;
  logic        req_valid, req_wipe, req_grant, hard_fault;
  logic        clk_en = 1;
  int          n_errors = 0, n_tests = 0;
  always #12.5 ref_clk = ~ref_clk;
  flash_req_model req_u (.ref_clk(ref_clk), .go(go), .addr(addr), .wipe(wipe), .req_valid(req_valid),
    .req_addr(req_addr), .req_wipe(req_wipe));
  flash_block_write_guard dut_u (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata),
    .debug_mode(debug_mode), .req_valid(req_valid), .req_addr(req_addr), .req_wipe(req_wipe),
    .req_grant(req_grant), .hard_fault(hard_fault));
  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk_reg
  // grant and fault are judged together: exactly one must answer
  task automatic chk_req(input string nm, input logic f);
    chk_reg(nm, {30'h0, ~f, f}, {30'h0, req_grant, hard_fault});
  endtask : chk_req
  task automatic wr(input logic [11:0] off, input logic [31:0] d);
    @(posedge ref_clk);
    bus_write <= 1;
    bus_addr  <= GUARD_BASE_ADDR | 32'(off);
    bus_wdata <= d;
    @(posedge ref_clk);
    bus_write <= 0;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    bus_read <= 1;
    bus_addr <= a;
    @(posedge ref_clk);
    bus_read <= 0;
    #1 chk_reg("rdata", e, bus_rdata);
  endtask : rd
  task automatic rq(input logic [31:0] a, input logic w, input logic f);
    @(posedge ref_clk);
    go   <= 1;
    addr <= a;
    wipe <= w;
    @(posedge ref_clk);
    go <= 0;
    @(posedge ref_clk);
    #1 chk_req("grant_fault", f);
  endtask : rq
  task automatic t_reset();
    rd(32'h4000_0600, 32'h0);
    rd(32'h4000_0604, 32'h0);
    rd(32'h4000_0608, 32'h1);
    rd(32'h5000_0600, 32'h0);
    rq(32'h0, 1, 0);
  endtask : t_reset
  task automatic t_maps();
    wr(12'h600, 32'h2);
    wr(12'h600, 32'h0);
    rd(32'h4000_0600, 32'h2);
    wr(12'h604, 32'hffff_ffff);
    wr(12'h60c, 32'h5);
    rd(32'h4000_0604, 32'h0000_ffff);
    rd(32'h4000_060c, 32'h0);
    // frozen clock enable must drop the write
    clk_en <= 0;
    wr(12'h600, 32'h4);
    clk_en <= 1;
    rd(32'h4000_0600, 32'h2);
  endtask : t_maps
  task automatic t_req();
    rq(32'h1fff, 0, 1);
    rq(32'h0fff, 0, 0);
    rq(32'h2_0000, 0, 1);
    rq(32'h2_ffff, 0, 1);
    rq(32'h3_0000, 0, 0);
    rq(32'h3_0000, 1, 1);
  endtask : t_req
  task automatic t_debug();
    debug_mode <= 1;
    rq(32'h1000, 0, 0);
    wr(12'h608, 32'h0);
    rd(32'h4000_0608, 32'h0);
    rq(32'h1000, 0, 1);
    wr(12'h608, 32'h1);
    debug_mode <= 0;
    rq(32'h1000, 0, 1);
  endtask : t_debug
  task automatic t_clear();
    @(posedge ref_clk);
    rst <= 1;
    @(posedge ref_clk);
    rst <= 0;
    rd(32'h4000_0600, 32'h0);
    rd(32'h4000_0604, 32'h0);
    rd(32'h4000_0608, 32'h1);
  endtask : t_clear
  task automatic end_of_test();
    if (n_errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  initial
  begin
    repeat (8) @(posedge ref_clk);
    rst <= 0;
    t_reset();
    t_maps();
    t_req();
    t_debug();
    t_clear();
    end_of_test();
  end
  // watchdog: the run needs about 80 cycles
  initial
  begin
    #20000;
    n_errors++;
    end_of_test();
  end
endmodule : flash_block_write_guard_tb
